// ==== design/hss_top.sv ====
/*
 * Hub strap sampler top: strap capture, derived settings,
 * status drive of shared pins and downstream port power.
 * Registers over classic Wishbone, 32-bit, byte addresses.
 * Assumes inputs synchronous to sys_clk; board keeps its straps.
 */
// Overview of operation
// RULE1: latch full-power strap at reset release; high: no switching or overcurrent.
// RULE2: low full-power strap: switching and overcurrent inputs used.
// RULE3: full power management drives four power and charge-enable outputs.
// RULE4: full-power strap loads full-auto bit; charging boards enable it.
// RULE5: auto mode on, full-auto low: all alternate profiles.
// RULE6: auto mode on, full-auto high: highest-current profile only.
// RULE7: SMBus mode: full-power strap is slave address bit 1.
// RULE8: status enabled: full-power pin shows upstream SuperSpeed connection.
// RULE9: latch polarity strap; 0 active-low, 1 active-high power outputs.
// RULE10: latch gang strap; 0 per-port, 1 ganged power control.
// RULE11: SMBus mode: gang strap is slave address bit 2.
// RULE12: status enabled: gang pin shows upstream High-speed connection.
// RULE13: charging boards must strap power switching supported.
// RULE14: charging boards must strap individual port power.
// RULE15: latch automatic-charge strap at reset release.
// RULE16: auto strap 0 enables auto mode, 1 disables; loads auto-enable bit.
// RULE17: bus-mode strap 1 selects I2C master, 0 SMBus slave.
// RULE18: straps captured once after reset, held until next reset.
// RULE19: status enable clear: shared strap pins never driven.
`timescale 1ns/10ps
`default_nettype none
`include "hss_regs.svh"

module hss_top #(
   parameter int         NPORTS        = 4,
   parameter logic [6:0] SMB_ADDR_BASE = 7'h44
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,

   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,

   // full-power / address bit 1 / SuperSpeed status pin
   input  wire logic              full_power_mgmt_strap_n_i,
   output logic                   full_power_mgmt_strap_n_o,
   output logic                   full_power_mgmt_strap_n_oe,

   // gang / address bit 2 / High-speed status pin
   input  wire logic              gang_strap_i,
   output logic                   highspeed_link_status_out,
   output logic                   gang_strap_oe,

   // input-only straps
   input  wire logic              power_out_polarity_strap,
   input  wire logic              auto_charge_strap_n,
   input  wire logic              bus_mode_strap_n,

   // hub core status
   input  wire logic              ss_link_up,
   input  wire logic              hs_link_up,

   // downstream power switches
   input  wire logic [NPORTS-1:0] overcurrent_n,
   output logic      [NPORTS-1:0] port_power_out,
   output logic      [NPORTS-1:0] charge_enable_out,

   // configuration to hub core
   output logic      [2:0]        alternate_charge_profile,
   output logic                   all_profiles_auto_n,
   output logic                   auto_charge_enable_n,
   output logic                   i2c_master_mode,
   output logic      [6:0]        smbus_slave_addr
);

   hss_strap_if straps ();

   // strap capture
   hss_strap_latch u_latch (
      .sys_clk      (sys_clk),
      .resetn       (resetn),

      .full_pm_pin  (full_power_mgmt_strap_n_i),
      .polarity_pin (power_out_polarity_strap),
      .gang_pin     (gang_strap_i),
      .auto_pin     (auto_charge_strap_n),
      .bus_mode_pin (bus_mode_strap_n),
      .straps       (straps.src)
   );

   // software state
   logic              sts_en_q;
   logic              fullauto_n_q;
   logic              autoen_n_q;

   logic [NPORTS-1:0] power_req_q;
   logic [NPORTS-1:0] charge_req_q;

   logic [NPORTS-1:0] oc_sticky_q;
   logic [NPORTS-1:0] oc_sticky_d;
   logic [NPORTS-1:0] oc_event;

   logic              captured_q;

   logic              load_cfg;

   hss_power_ctl #(
      .NPORTS (NPORTS)
   ) u_power (
      .sys_clk           (sys_clk),
      .resetn            (resetn),

      .straps            (straps.dst),
      .power_req         (power_req_q),
      .charge_req        (charge_req_q),
      .overcurrent_n     (overcurrent_n),
      .port_power_out    (port_power_out),
      .charge_enable_out (charge_enable_out),
      .oc_event          (oc_event)
   );

   // bus decode
   logic        bus_req;
   logic        bus_wr;
   logic        lane0_wr;

   logic        hit_strap;
   logic        hit_ctrl;
   logic        hit_port;
   logic        hit_status;
   logic        hit_smbaddr;

   logic        ack_d;

   logic [31:0] rd_data;

   // one wait state: ack one edge after the request appears
   assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr      = bus_req & wb_we_i;
   assign lane0_wr    = bus_wr & wb_sel_i[0];

   assign hit_strap   = (wb_adr_i == `HSS_OFF_STRAP);
   assign hit_ctrl    = (wb_adr_i == `HSS_OFF_CTRL);
   assign hit_port    = (wb_adr_i == `HSS_OFF_PORT);
   assign hit_status  = (wb_adr_i == `HSS_OFF_STATUS);

   assign hit_smbaddr = (wb_adr_i == `HSS_OFF_SMBADDR);

   assign ack_d       = bus_req;

   // capture-to-config load happens once, the cycle the straps become held
   assign load_cfg = straps.captured & ~captured_q;

   // derived settings
   logic                  smbus_mode;
   logic [6:0]            smb_addr_d;

   hss_pkg::hss_profile_t profile_d;
   logic                  sts_drive;

   // RULE17 bus mode select
   assign smbus_mode = straps.captured & ~straps.bus_mode_n;

   // RULE7 address bit 1
   // RULE11 address bit 2
   assign smb_addr_d = smbus_mode ?
                       {SMB_ADDR_BASE[6:3], straps.gang, straps.full_pm_n, SMB_ADDR_BASE[0]} :
                       SMB_ADDR_BASE;

   // RULE5 all profiles
   // RULE6 highest profile only
   assign profile_d = (!straps.captured || autoen_n_q) ?
                      hss_pkg::HSS_PROF_OFF :
                      fullauto_n_q ? hss_pkg::HSS_PROF_HIGHEST :
                                     hss_pkg::HSS_PROF_ALL;

   // RULE19 no drive when disabled
   assign sts_drive = straps.captured & sts_en_q;

   // read mux
   always_comb begin
      rd_data = 32'h0000_0000;

      // straps as captured
      if (hit_strap) begin
         rd_data[`HSS_STRAP_FULL_PM_N]  = straps.full_pm_n;
         rd_data[`HSS_STRAP_POLARITY]   = straps.polarity;
         rd_data[`HSS_STRAP_GANG]       = straps.gang;
         rd_data[`HSS_STRAP_AUTO_N]     = straps.auto_n;
         rd_data[`HSS_STRAP_BUS_MODE_N] = straps.bus_mode_n;

         rd_data[`HSS_STRAP_CAPTURED]   = straps.captured;

      end else if (hit_ctrl) begin
         rd_data[`HSS_CTRL_STS_EN]     = sts_en_q;
         rd_data[`HSS_CTRL_FULLAUTO_N] = fullauto_n_q;
         rd_data[`HSS_CTRL_AUTOEN_N]   = autoen_n_q;

      end else if (hit_port) begin
         rd_data[`HSS_PORT_REQ_LSB +: NPORTS] = power_req_q;
         rd_data[`HSS_PORT_CHG_LSB +: NPORTS] = charge_req_q;

      end else if (hit_status) begin
         rd_data[`HSS_STAT_OC_LSB +: NPORTS] = oc_sticky_q;

         rd_data[`HSS_STAT_SS_UP]            = ss_link_up;
         rd_data[`HSS_STAT_HIGHSPEED_LINK_STATUS_OUT]            = hs_link_up;
         rd_data[`HSS_STAT_PROF_LSB +: 3]    = profile_d;

      end else if (hit_smbaddr) begin
         rd_data[`HSS_SMB_ADDR_LSB +: 7] = smb_addr_d;

         rd_data[`HSS_SMB_MODE]          = smbus_mode;
      end
   end

   // bus answer; unmapped offsets ack with zero data
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= ack_d;

         wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
      end
   end

   // status-output enable
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sts_en_q <= `HSS_CTRL_STS_EN_RST;
      end else if (lane0_wr && hit_ctrl) begin
         sts_en_q <= wb_dat_i[`HSS_CTRL_STS_EN];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         captured_q <= 1'b0;
      end else begin
         // one clock late marks the capture edge
         captured_q <= straps.captured;
      end
   end

   // strap load outranks software; it lands on edge 2 after release and overwrites a control write acked on edge 1
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fullauto_n_q <= 1'b0;
         autoen_n_q   <= 1'b0;
      end else if (load_cfg) begin
         // RULE4 full-auto from strap
         fullauto_n_q <= straps.full_pm_n;

         // RULE16 auto-enable from strap
         // RULE15 automatic-charge strap
         autoen_n_q   <= straps.auto_n;
      end else if (lane0_wr && hit_ctrl) begin
         fullauto_n_q <= wb_dat_i[`HSS_CTRL_FULLAUTO_N];
         autoen_n_q   <= wb_dat_i[`HSS_CTRL_AUTOEN_N];
      end
   end

   // port requests
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         power_req_q  <= NPORTS'(`HSS_PORT_RST);
         charge_req_q <= NPORTS'(`HSS_PORT_RST);
      end else if (lane0_wr && hit_port) begin
         // lane 0 only: other lanes hold no writable bits
         power_req_q  <= wb_dat_i[`HSS_PORT_REQ_LSB +: NPORTS];
         charge_req_q <= wb_dat_i[`HSS_PORT_CHG_LSB +: NPORTS];
      end
   end

   // overcurrent sticky flags, write one to clear; a new event wins

   genvar i;
   generate
      for (i = 0; i < NPORTS; i++) begin : g_oc
         assign oc_sticky_d[i] = oc_event[i] |
            (oc_sticky_q[i] &
             ~(lane0_wr & hit_status & wb_dat_i[`HSS_STAT_OC_LSB + i]));
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         oc_sticky_q <= '0;
      end else begin
         oc_sticky_q <= oc_sticky_d;
      end
   end

   // shared pins: released through reset and the capture cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         full_power_mgmt_strap_n_o  <= 1'b0;
         full_power_mgmt_strap_n_oe <= 1'b0;
         highspeed_link_status_out  <= 1'b0;

         gang_strap_oe              <= 1'b0;
      end else begin
         // RULE8 SuperSpeed status out
         full_power_mgmt_strap_n_o  <= ss_link_up;
         full_power_mgmt_strap_n_oe <= sts_drive;

         // RULE12 High-speed status out
         highspeed_link_status_out  <= hs_link_up;
         gang_strap_oe              <= sts_drive;
      end
   end

   // configuration to the hub core
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         alternate_charge_profile <= hss_pkg::HSS_PROF_OFF;
         all_profiles_auto_n      <= 1'b0;
         auto_charge_enable_n     <= 1'b1;
         i2c_master_mode          <= 1'b0;
         smbus_slave_addr         <= 7'h00;
      end else begin
         alternate_charge_profile <= profile_d;

         all_profiles_auto_n      <= fullauto_n_q;
         auto_charge_enable_n     <= straps.captured ? autoen_n_q : 1'b1;
         i2c_master_mode          <= straps.captured & straps.bus_mode_n;

         smbus_slave_addr         <= smb_addr_d;
      end
   end

endmodule

`default_nettype wire

// ==== design/hss_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * hub strap sampler. Assumes byte addresses on a 32-bit classic Wishbone bus.
 */
`ifndef HSS_REGS_SVH
`define HSS_REGS_SVH

// register byte offsets
`define HSS_OFF_STRAP        8'h00
`define HSS_OFF_CTRL         8'h04
`define HSS_OFF_PORT         8'h08
`define HSS_OFF_STATUS       8'h0c
`define HSS_OFF_SMBADDR      8'h10

// strap register fields
`define HSS_STRAP_FULL_PM_N  0
`define HSS_STRAP_POLARITY   1
`define HSS_STRAP_GANG       2
`define HSS_STRAP_AUTO_N     3
`define HSS_STRAP_BUS_MODE_N 4
`define HSS_STRAP_CAPTURED   5

// control register fields
`define HSS_CTRL_STS_EN      0
`define HSS_CTRL_FULLAUTO_N  1
`define HSS_CTRL_AUTOEN_N    2
`define HSS_CTRL_STS_EN_RST  1'b0

// port register fields
`define HSS_PORT_REQ_LSB     0
`define HSS_PORT_CHG_LSB     4
`define HSS_PORT_RST         8'h00

// status register fields
`define HSS_STAT_OC_LSB      0
`define HSS_STAT_SS_UP       4
`define HSS_STAT_HIGHSPEED_LINK_STATUS_OUT       5
`define HSS_STAT_PROF_LSB    6

// slave address register fields
`define HSS_SMB_ADDR_LSB     0
`define HSS_SMB_MODE         8

// timing: straps are captured in the first clock after reset release
`define HSS_CAPTURE_CYCLES   1

`endif

// ==== design/hss_pkg.sv ====
/*
 * Types shared by the hub strap sampler modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hss_pkg;

   // strap capture sequencer, one-hot
   typedef enum logic [1:0] {
      HSS_ST_WAIT = 2'b01,
      HSS_ST_HELD = 2'b10
   } hss_state_t;

   // alternate charging profile permitted in automatic mode, one-hot
   typedef enum logic [2:0] {
      HSS_PROF_OFF     = 3'b001,
      HSS_PROF_ALL     = 3'b010,
      HSS_PROF_HIGHEST = 3'b100
   } hss_profile_t;

endpackage

// ==== design/hss_strap_if.sv ====
/*
 * Carries the captured strap levels from the latch to their users.
 * Assumes one clock domain; all signals come from flip-flops of the latch.
 */
`timescale 1ns/10ps
`default_nettype none

interface hss_strap_if;
   logic captured, full_pm_n, polarity, gang, auto_n, bus_mode_n;

   modport src (output captured, full_pm_n, polarity, gang, auto_n, bus_mode_n);
   modport dst (input captured, full_pm_n, polarity, gang, auto_n, bus_mode_n);
endinterface

`default_nettype wire

// ==== design/hss_strap_latch.sv ====
/*
 * Captures the configuration straps once after reset release and holds them.
 * Assumes the shared pins are not driven by this device while waiting.
 */
`timescale 1ns/10ps
`default_nettype none

module hss_strap_latch (
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     resetn,
   // strap pin levels
   input  wire logic     full_pm_pin,
   input  wire logic     polarity_pin,
   input  wire logic     gang_pin,
   input  wire logic     auto_pin,
   input  wire logic     bus_mode_pin,
   // captured values
   hss_strap_if.src      straps
);

   hss_pkg::hss_state_t state_q;
   hss_pkg::hss_state_t state_d;
   logic                take;
   logic [4:0]          val_q;

   assign take    = (state_q == hss_pkg::HSS_ST_WAIT);
   assign state_d = take ? hss_pkg::HSS_ST_HELD : state_q;

   // async reset loads constants only; pins are sampled on the first clock
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= hss_pkg::HSS_ST_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   // RULE18 capture once, hold
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         val_q <= 5'h00;
      end else if (take) begin
         val_q <= {bus_mode_pin, auto_pin, gang_pin, polarity_pin, full_pm_pin};
      end
   end

   assign straps.captured   = (state_q == hss_pkg::HSS_ST_HELD);
   assign straps.full_pm_n  = val_q[0];
   assign straps.polarity   = val_q[1];
   assign straps.gang       = val_q[2];
   assign straps.auto_n     = val_q[3];
   assign straps.bus_mode_n = val_q[4];

endmodule

`default_nettype wire

// ==== design/hss_power_ctl.sv ====
/*
 * Downstream port power and charge-enable outputs with overcurrent cut-off.
 * Assumes overcurrent inputs are synchronous and active low.
 */
`timescale 1ns/10ps
`default_nettype none

module hss_power_ctl #(
   parameter int NPORTS = 4
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // captured straps
   hss_strap_if.dst               straps,
   // software requests
   input  wire logic [NPORTS-1:0] power_req,
   input  wire logic [NPORTS-1:0] charge_req,
   // switch feedback
   input  wire logic [NPORTS-1:0] overcurrent_n,
   // outputs
   output logic      [NPORTS-1:0] port_power_out,
   output logic      [NPORTS-1:0] charge_enable_out,
   output logic      [NPORTS-1:0] oc_event
);

   logic              switching_ok;
   logic [NPORTS-1:0] oc_seen;
   logic [NPORTS-1:0] port_on;
   logic [NPORTS-1:0] power_d;
   logic [NPORTS-1:0] charge_d;
   logic              any_req;
   logic              any_oc;

   // RULE1 high strap: no switching
   // RULE2 low strap: switching and sensing used
   assign switching_ok = straps.captured & ~straps.full_pm_n;
   assign oc_seen      = switching_ok ? ~overcurrent_n : '0;
   assign any_req      = |power_req;
   assign any_oc       = |oc_seen;
   assign oc_event     = oc_seen;

   genvar i;
   generate
      for (i = 0; i < NPORTS; i++) begin : g_port
         // RULE10 gang or per-port
         assign port_on[i] = switching_ok &
                             (straps.gang ? (any_req & ~any_oc)
                                          : (power_req[i] & ~oc_seen[i]));
         // RULE9 output polarity
         assign power_d[i] = straps.polarity ? port_on[i] : ~port_on[i];
         // RULE3 per-port charge enable
         assign charge_d[i] = port_on[i] & charge_req[i];
      end
   endgenerate

   // outputs read low in reset: polarity is not known until the capture
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         port_power_out    <= '0;
         charge_enable_out <= '0;
      end else begin
         port_power_out    <= power_d;
         charge_enable_out <= charge_d;
      end
   end

endmodule

`default_nettype wire

// ==== bench/hss_board_model.sv ====
/*
 * Board side: strap resistors and power switch overcurrent flags.
 * Assumes the bench picks straps and faults.
 */
`timescale 1ns/10ps
`default_nettype none

module hss_board_model (
   // board choices
   input  wire logic [4:0] st,
   input  wire logic       chg,
   input  wire logic [3:0] fault,
   // device drive of the shared pins
   input  wire logic       full_power_mgmt_strap_n_o,
   input  wire logic       full_power_mgmt_strap_n_oe,
   input  wire logic       highspeed_link_status_out,
   input  wire logic       gang_strap_oe,
   // levels at the device pins
   output logic            full_power_mgmt_strap_n_i,
   output logic            gang_strap_i,
   output logic            power_out_polarity_strap,
   output logic            auto_charge_strap_n,
   output logic            bus_mode_strap_n,
   output logic [3:0]      overcurrent_n
);
   logic [4:0] lvl;

   assign lvl = chg ? (st & 5'h1a) : st;
   // resistor level only shows while the device leaves the pin alone
   assign full_power_mgmt_strap_n_i = full_power_mgmt_strap_n_oe ?
                                      full_power_mgmt_strap_n_o : lvl[0];
   assign gang_strap_i = gang_strap_oe ? highspeed_link_status_out : lvl[2];
   assign power_out_polarity_strap = lvl[1];
   assign auto_charge_strap_n = lvl[3];
   assign bus_mode_strap_n = lvl[4];
   assign overcurrent_n = ~fault;
endmodule

`default_nettype wire

// ==== bench/hss_top_chk.sv ====
/*
 * Checks on the strap sampler top ports.
 * Assumes software rewrites strap-loaded control bits unchanged.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hss_regs.svh"

module hss_top_chk #(
   parameter int NPORTS = 4
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // bus
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic              wb_ack_o,
   // pins and config
   input  wire logic              full_power_mgmt_strap_n_i,
   input  wire logic              full_power_mgmt_strap_n_o,
   input  wire logic              full_power_mgmt_strap_n_oe,
   input  wire logic              gang_strap_i,
   input  wire logic              highspeed_link_status_out,
   input  wire logic              gang_strap_oe,
   input  wire logic              power_out_polarity_strap,
   input  wire logic              auto_charge_strap_n,
   input  wire logic              bus_mode_strap_n,
   input  wire logic              ss_link_up,
   input  wire logic              hs_link_up,
   input  wire logic [NPORTS-1:0] port_power_out,
   input  wire logic [NPORTS-1:0] charge_enable_out,
   input  wire logic [2:0]        alternate_charge_profile,
   input  wire logic              all_profiles_auto_n,
   input  wire logic              auto_charge_enable_n,
   input  wire logic              i2c_master_mode,
   input  wire logic [6:0]        smbus_slave_addr
);
   logic [1:0] cnt_q;
   logic [4:0] s_q;
   logic       sts_q;
   logic       wr_ctl;
   logic       done;

   assign wr_ctl = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0]
                   & (wb_adr_i == `HSS_OFF_CTRL);
   // settled once edge 3 after release has passed
   assign done = cnt_q == 2'h3;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 2'h0;
         s_q   <= 5'h0;
         sts_q <= 1'b0;
      end else begin
         if (!done) cnt_q <= cnt_q + 2'h1;
         if (cnt_q == 2'h0) s_q <= {bus_mode_strap_n, auto_charge_strap_n, gang_strap_i,
                                    power_out_polarity_strap, full_power_mgmt_strap_n_i};
         if (wr_ctl) sts_q <= wb_dat_i[0];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   chk_status_drive_on: assert property (sts_q && cnt_q != 2'h0 |=> full_power_mgmt_strap_n_oe && gang_strap_oe)
      else $error("status pins not driven");
   chk_status_drive_off: assert property (!(sts_q && cnt_q != 2'h0) |=> !full_power_mgmt_strap_n_oe && !gang_strap_oe)
      else $error("status pins driven while disabled");
   chk_ss_follow: assert property (full_power_mgmt_strap_n_oe |-> full_power_mgmt_strap_n_o == $past(ss_link_up))
      else $error("superspeed status wrong");
   chk_hs_follow: assert property (gang_strap_oe |-> highspeed_link_status_out == $past(hs_link_up))
      else $error("highspeed status wrong");
   chk_config_held: assert property (done |-> $stable(i2c_master_mode) && $stable(smbus_slave_addr))
      else $error("captured config moved");
   chk_bus_mode_sel: assert property (done |-> i2c_master_mode == s_q[4])
      else $error("bus mode wrong");
   chk_addr_bits: assert property (done && !s_q[4] |-> smbus_slave_addr[2:1] == {s_q[2], s_q[0]})
      else $error("slave address bits wrong");
   chk_cfg_bits: assert property (done |-> auto_charge_enable_n == s_q[3] && all_profiles_auto_n == s_q[0])
      else $error("config bits not from straps");
   chk_profile_pick: assert property (done && !auto_charge_enable_n |-> alternate_charge_profile == (all_profiles_auto_n ? hss_pkg::HSS_PROF_HIGHEST : hss_pkg::HSS_PROF_ALL))
      else $error("charge profile wrong");
   chk_no_switching: assert property (done && s_q[0] |-> port_power_out == {NPORTS{!s_q[1]}} && charge_enable_out == '0)
      else $error("ports powered without switching");

   cover property ($rose(full_power_mgmt_strap_n_oe));
   cover property (done && alternate_charge_profile == hss_pkg::HSS_PROF_HIGHEST);
   cover property (wb_ack_o && !wb_we_i);
endmodule

bind hss_top hss_top_chk #(.NPORTS(NPORTS)) u_hss_top_chk (.*);

`default_nettype wire

// ==== bench/hss_top_tb_top.sv ====
/*
 * Self-checking strap sampler bench.
 * Assumes board model and checker compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hss_regs.svh"

module hss_top_tb_top;
   localparam logic [6:0] BASE = 7'h5a;
   logic        sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, look, chg;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, fault, req, cg, of, overcurrent_n, port_power_out, charge_enable_out;
   logic [31:0] wb_dat_i, wb_dat_o, pins, rq[$], pq[$];
   logic [4:0]  st, e;
   logic [6:0]  ea, smbus_slave_addr;
   logic [2:0]  ep, alternate_charge_profile;
   logic        full_power_mgmt_strap_n_i, full_power_mgmt_strap_n_o;
   logic        full_power_mgmt_strap_n_oe, gang_strap_i, highspeed_link_status_out;
   logic        gang_strap_oe, power_out_polarity_strap, auto_charge_strap_n;
   logic        bus_mode_strap_n, ss_link_up, hs_link_up, all_profiles_auto_n;
   logic        auto_charge_enable_n, i2c_master_mode;
   int          n_fail = 0, checked = 0, cycles = 0;

   assign pins = {9'h0, port_power_out, charge_enable_out, alternate_charge_profile,
                  all_profiles_auto_n, auto_charge_enable_n, i2c_master_mode,
                  smbus_slave_addr, full_power_mgmt_strap_n_oe, gang_strap_oe};

   hss_top #(.SMB_ADDR_BASE(BASE)) u_hss_top (.*);

   hss_board_model u_hss_board_model (.*);

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic stop_test;
      if (n_fail == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask

   // monitor: oldest note against each result as it appears
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         stop_test;
      end
      if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, rq.pop_front());
      if (look) chk(pins, pq.pop_front());
   end

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'($urandom) | 4'h1;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      rq.push_back(x);
      wb(1'b0, a, 32'h0);
   endtask

   // sample settled outputs on the fourth edge
   task automatic pin(input logic [31:0] x);
      repeat (3) @(posedge sys_clk);
      pq.push_back(x);
      look <= 1'b1;
      @(posedge sys_clk);
      look <= 1'b0;
   endtask

   function automatic logic [31:0] ex(input logic [3:0] r, input logic [3:0] c,
                                      input logic [3:0] o, input logic oe);
      logic [3:0] on;
      on = e[0] ? 4'h0 : e[2] ? {4{|r && o == 4'h0}} : r & ~o;
      return {9'h0, e[1] ? on : ~on, on & c, ep, e[0], e[3], e[4], ea, oe, oe};
   endfunction

   initial begin
      void'($urandom(32'h3d0c658b));
      {wb_cyc_i, wb_stb_i, wb_we_i, look, resetn, chg, ss_link_up, hs_link_up} = 8'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i, st, fault} = '0;
      for (int it = 0; it < 8; it++) begin
         resetn <= 1'b0;
         chg    <= it[0];
         e = {it[1], it[2], 3'($urandom)};
         st     <= e;
         if (it[0]) e = e & 5'h1a;
         {ss_link_up, hs_link_up} <= 2'($urandom);
         fault  <= 4'h0;
         repeat (20) @(posedge sys_clk);
         resetn <= 1'b1;
         ea = BASE;
         if (!e[4]) ea[2:1] = {e[2], e[0]};
         ep = e[3] ? hss_pkg::HSS_PROF_OFF : e[0] ? hss_pkg::HSS_PROF_HIGHEST : hss_pkg::HSS_PROF_ALL;
         pin(ex(4'h0, 4'h0, 4'h0, 1'b0));
         rd(`HSS_OFF_CTRL, {29'h0, e[3], e[0], 1'b0});
         rd(`HSS_OFF_SMBADDR, {23'h0, ~e[4], 1'b0, ea});
         wb(1'b1, `HSS_OFF_STRAP, 32'hffff_ffff);
         st <= ~st;
         rd(`HSS_OFF_STRAP, {26'h0, 1'b1, e});
         rd(8'h20, 32'h0);
         req = 4'($urandom);
         cg  = 4'($urandom);
         wb(1'b1, `HSS_OFF_PORT, {24'h0, cg, req});
         pin(ex(req, cg, 4'h0, 1'b0));
         of = 4'h1 << it[2:1];
         fault <= of;
         pin(ex(req, cg, of, 1'b0));
         rd(`HSS_OFF_STATUS, {23'h0, ep, hs_link_up, ss_link_up, e[0] ? 4'h0 : of});
         wb(1'b1, `HSS_OFF_CTRL, {29'h0, e[3], e[0], 1'b1});
         pin(ex(req, cg, of, 1'b1));
         {ss_link_up, hs_link_up} <= ~{ss_link_up, hs_link_up};
         wb(1'b1, `HSS_OFF_CTRL, {29'h0, e[3], e[0], 1'b0});
         pin(ex(req, cg, of, 1'b0));
      end
      stop_test;
   end
endmodule

`default_nettype wire
